// >>> core/nfh_ctrl.sv
// Host controller for an 8-bit multiplexed NAND flash port, with write FIFO
`include "nfh_defines.svh"
`default_nettype none

// ----------------------------------------
// Write data FIFO
// ----------------------------------------
module nfh_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Filling side
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    // Draining side
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH]; // Storage words
    logic [AW-1:0] wp_r, wp_nxt; // Write index
    logic [AW-1:0] rp_r, rp_nxt; // Read index
    logic [AW:0] cnt_r, cnt_nxt; // Fill level
    logic in_ready_nxt; // Room left after this cycle
    logic push, pop;

    // Next indices and level
    always_comb begin
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        wp_nxt = push ? ((wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1) : wp_r;
        rp_nxt = pop ? ((rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1) : rp_r;
        cnt_nxt = cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
        in_ready_nxt = (cnt_nxt != (AW + 1)'(DEPTH));
    end

    // Register indices, level and storage
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            in_ready_o <= 1'b1;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
            // Registered so that the not-full flag leaves the block from a flop
            in_ready_o <= in_ready_nxt;
        end
    end
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wp_r] <= in_data_i;
        end
    end

    // Empty flag and head word
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o = mem_r[rp_r];
endmodule

// ----------------------------------------
// Flash host sequencer
// ----------------------------------------
module nfh_ctrl
    import nfh_pkg::*;
#(
    parameter int FIFO_DEPTH = 8,
    parameter int LEN_W = 13
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // User command port
    input wire logic cmd_valid_i,
    input wire nfh_pkg::nfh_op_t cmd_op_i,
    input wire logic [39:0] cmd_addr_i,
    input wire logic [LEN_W-1:0] cmd_len_i,
    output logic cmd_ready_o,
    output logic done_o,
    // Program data in
    input wire logic wr_valid_i,
    input wire logic [7:0] wr_data_i,
    output logic wr_ready_o,
    // Read and status data out
    output logic rd_valid_o,
    output logic [7:0] rd_data_o,
    // Flash pins
    output logic ce_n_o,
    output logic cle_o,
    output logic ale_o,
    output logic we_n_o,
    output logic read_strobe_n_o,
    output logic wp_n_o,
    input wire logic [7:0] shared_io_bus_i,
    output logic [7:0] shared_io_bus_o,
    output logic shared_io_bus_oe_o,
    input wire logic rb_n_i
);
    import nfh_pkg::*;
    localparam logic [2:0] ACC = 3'(`NFH_RD_ACCESS_CYC);
    localparam logic [2:0] SETTLE = 3'(`NFH_SETTLE_CYC);

    nfh_state_t st_r, st_nxt; // Sequencer state
    nfh_op_t op_r, op_nxt; // Current operation
    logic [1:0] stage_r, stage_nxt; // 0 first cmd, 1 second cmd, 2 status cmd
    logic [2:0] ph_r, ph_nxt; // Strobe phase
    logic [2:0] aidx_r, aidx_nxt; // Address cycle index
    logic [39:0] addr_r, addr_nxt; // Column and row address
    logic [LEN_W-1:0] len_r, len_nxt; // Bytes left
    logic [7:0] cbyte_r, cbyte_nxt; // Command byte to issue
    logic rb_s1_r, rb_s2_r, rb_q_r; // R/B synchroniser
    logic ce_nxt, cle_nxt, ale_nxt, we_nxt, rds_nxt, wp_nxt, oe_nxt;
    logic [7:0] bus_nxt, rd_nxt;
    logic rdv_nxt, done_nxt, rdy_nxt, fifo_pop;
    logic fifo_v;
    logic [7:0] fifo_d;

    // Write data buffer; the sequencer drains it one byte per WE cycle
    nfh_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .in_valid_i(wr_valid_i),
        .in_data_i(wr_data_i),
        .in_ready_o(wr_ready_o),
        .out_valid_o(fifo_v),
        .out_data_o(fifo_d),
        .out_ready_i(fifo_pop)
    );

    // Two-flop synchroniser plus a qualified copy for the sequencer
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rb_s1_r <= 1'b0;
            rb_s2_r <= 1'b0;
            rb_q_r <= 1'b0;
        end else begin
            rb_s1_r <= rb_n_i;
            rb_s2_r <= rb_s1_r;
            rb_q_r <= rb_s2_r;
        end
    end

    // Sequencer next state and pin values
    always_comb begin
        st_nxt = st_r;
        op_nxt = op_r;
        stage_nxt = stage_r;
        ph_nxt = ph_r;
        aidx_nxt = aidx_r;
        addr_nxt = addr_r;
        len_nxt = len_r;
        cbyte_nxt = cbyte_r;
        ce_nxt = ce_n_o;
        cle_nxt = cle_o;
        ale_nxt = ale_o;
        we_nxt = we_n_o;
        rds_nxt = read_strobe_n_o;
        wp_nxt = wp_n_o;
        oe_nxt = shared_io_bus_oe_o;
        bus_nxt = shared_io_bus_o;
        rd_nxt = rd_data_o;
        rdv_nxt = 1'b0;
        done_nxt = 1'b0;
        fifo_pop = 1'b0;
        case (st_r)
            NFH_S_IDLE: begin
                ce_nxt = 1'b1;
                oe_nxt = 1'b0;
                // New work only while the device reports ready
                if (cmd_valid_i && cmd_ready_o) begin
                    op_nxt = cmd_op_i;
                    addr_nxt = cmd_addr_i;
                    len_nxt = cmd_len_i;
                    stage_nxt = 2'h0;
                    ph_nxt = '0;
                    ce_nxt = 1'b0;
                    // Lift protection only for program and erase
                    wp_nxt = (cmd_op_i == NFH_OP_PROG) || (cmd_op_i == NFH_OP_ERASE);
                    case (cmd_op_i)
                        NFH_OP_READ: cbyte_nxt = `NFH_CMD_READ1;
                        NFH_OP_PROG: cbyte_nxt = `NFH_CMD_PROG1;
                        NFH_OP_ERASE: cbyte_nxt = `NFH_CMD_ERASE1;
                        NFH_OP_RESET: cbyte_nxt = `NFH_CMD_RESET;
                        default: begin
                            // Undefined codes run as a plain status read
                            op_nxt = NFH_OP_STATUS;
                            cbyte_nxt = `NFH_CMD_STATUS;
                        end
                    endcase
                    st_nxt = NFH_S_CMD;
                end
            end
            NFH_S_CMD: begin
                if (ph_r == '0) begin
                    // Command on bus with CLE, WE low
                    cle_nxt = 1'b1;
                    ale_nxt = 1'b0;
                    oe_nxt = 1'b1;
                    bus_nxt = cbyte_r;
                    we_nxt = 1'b0;
                    ph_nxt = 3'h1;
                end else begin
                    we_nxt = 1'b1;
                    ph_nxt = '0;
                    if (stage_r == 2'h2 || op_r == NFH_OP_STATUS) begin
                        len_nxt = LEN_W'(1);
                        st_nxt = NFH_S_RDAT;
                    end else if (stage_r == 2'h1 || op_r == NFH_OP_RESET) begin
                        st_nxt = NFH_S_WAIT;
                    end else begin
                        // Erase skips the column cycles
                        aidx_nxt = (op_r == NFH_OP_ERASE) ? `NFH_ADDR_FIRST_ROW : '0;
                        st_nxt = NFH_S_ADDR;
                    end
                end
            end
            NFH_S_ADDR: begin
                if (ph_r == '0) begin
                    cle_nxt = 1'b0;
                    ale_nxt = 1'b1;
                    oe_nxt = 1'b1;
                    bus_nxt = addr_r[8*aidx_r +: 8];
                    we_nxt = 1'b0;
                    ph_nxt = 3'h1;
                end else begin
                    we_nxt = 1'b1;
                    ph_nxt = '0;
                    aidx_nxt = aidx_r + 3'h1;
                    if (aidx_r == `NFH_ADDR_CYC_FULL - 3'h1) begin
                        stage_nxt = 2'h1;
                        if (op_r == NFH_OP_PROG) begin
                            st_nxt = NFH_S_WDAT;
                        end else begin
                            cbyte_nxt = (op_r == NFH_OP_READ) ? `NFH_CMD_READ2
                                                               : `NFH_CMD_ERASE2;
                            st_nxt = NFH_S_CMD;
                        end
                    end
                end
            end
            NFH_S_WDAT: begin
                if (ph_r == '0) begin
                    ale_nxt = 1'b0;
                    // Stall while the FIFO is empty
                    if (len_r == '0) begin
                        cbyte_nxt = `NFH_CMD_PROG2;
                        st_nxt = NFH_S_CMD;
                    end else if (fifo_v) begin
                        fifo_pop = 1'b1;
                        oe_nxt = 1'b1;
                        bus_nxt = fifo_d;
                        we_nxt = 1'b0;
                        len_nxt = len_r - LEN_W'(1);
                        ph_nxt = 3'h1;
                    end
                end else begin
                    we_nxt = 1'b1;
                    ph_nxt = '0;
                end
            end
            NFH_S_WAIT: begin
                cle_nxt = 1'b0;
                ale_nxt = 1'b0;
                oe_nxt = 1'b0;
                // Let R/B fall, then wait for ready
                if (ph_r != SETTLE) begin
                    ph_nxt = ph_r + 3'h1;
                end else if (rb_q_r) begin
                    ph_nxt = '0;
                    wp_nxt = 1'b0;
                    if (op_r == NFH_OP_READ) begin
                        st_nxt = NFH_S_RDAT;
                    end else if (op_r == NFH_OP_RESET) begin
                        done_nxt = 1'b1;
                        st_nxt = NFH_S_IDLE;
                    end else begin
                        stage_nxt = 2'h2;
                        cbyte_nxt = `NFH_CMD_STATUS;
                        st_nxt = NFH_S_CMD;
                    end
                end
            end
            NFH_S_RDAT: begin
                cle_nxt = 1'b0;
                oe_nxt = 1'b0;
                if (len_r == '0) begin
                    done_nxt = 1'b1;
                    st_nxt = NFH_S_IDLE;
                end else if (ph_r == '0) begin
                    rds_nxt = 1'b0;
                    ph_nxt = 3'h1;
                end else if (ph_r != ACC + 3'h1) begin
                    ph_nxt = ph_r + 3'h1;
                end else begin
                    // Sample after the access delay, then end the read cycle
                    rd_nxt = shared_io_bus_i;
                    rdv_nxt = 1'b1;
                    rds_nxt = 1'b1;
                    len_nxt = len_r - LEN_W'(1);
                    ph_nxt = '0;
                end
            end
            default: begin
                st_nxt = NFH_S_IDLE;
            end
        endcase
        rdy_nxt = (st_nxt == NFH_S_IDLE) && rb_s2_r && !(st_r == NFH_S_IDLE && cmd_valid_i
                  && cmd_ready_o);
    end

    // Register sequencer state and all pin outputs
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_r <= NFH_S_IDLE;
            op_r <= NFH_OP_READ;
            stage_r <= '0;
            ph_r <= '0;
            aidx_r <= '0;
            addr_r <= '0;
            len_r <= '0;
            cbyte_r <= '0;
            ce_n_o <= 1'b1;
            cle_o <= 1'b0;
            ale_o <= 1'b0;
            we_n_o <= 1'b1;
            read_strobe_n_o <= 1'b1;
            wp_n_o <= 1'b0;
            shared_io_bus_oe_o <= 1'b0;
            shared_io_bus_o <= '0;
            rd_data_o <= '0;
            rd_valid_o <= 1'b0;
            done_o <= 1'b0;
            cmd_ready_o <= 1'b0;
        end else begin
            st_r <= st_nxt;
            op_r <= op_nxt;
            stage_r <= stage_nxt;
            ph_r <= ph_nxt;
            aidx_r <= aidx_nxt;
            addr_r <= addr_nxt;
            len_r <= len_nxt;
            cbyte_r <= cbyte_nxt;
            ce_n_o <= ce_nxt;
            cle_o <= cle_nxt;
            ale_o <= ale_nxt;
            we_n_o <= we_nxt;
            read_strobe_n_o <= rds_nxt;
            wp_n_o <= wp_nxt;
            shared_io_bus_oe_o <= oe_nxt;
            shared_io_bus_o <= bus_nxt;
            rd_data_o <= rd_nxt;
            rd_valid_o <= rdv_nxt;
            done_o <= done_nxt;
            cmd_ready_o <= rdy_nxt;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic [2:0] acnt_h; // Address cycles since last command other than READ2 or ERASE2
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            acnt_h <= '0;
        end else if (!we_n_o && cle_o) begin
            acnt_h <= (cbyte_r == `NFH_CMD_READ2 || cbyte_r == `NFH_CMD_ERASE2) ? acnt_h : '0;
        end else if (!we_n_o && ale_o && we_nxt) begin
            acnt_h <= acnt_h + 3'h1;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_cmd_strobe(logic [7:0] c);
        cle_o && !we_n_o && shared_io_bus_o == c ##1 we_n_o;
    endsequence

    // Read strobe held low two cycles, then released
    sequence s_read_cycle;
        !read_strobe_n_o [*2] ##1 read_strobe_n_o;
    endsequence

    a_latch_excl: assert property (!(cle_o && ale_o))
        else $error("CLE and ALE high together");
    a_cmd_driven: assert property ($rose(we_n_o) && cle_o |-> shared_io_bus_oe_o)
        else $error("command strobe without bus drive");
    a_addr_driven: assert property ($rose(we_n_o) && ale_o |-> shared_io_bus_oe_o)
        else $error("address strobe without bus drive");
    a_strobe_select: assert property (!we_n_o || !read_strobe_n_o |-> !ce_n_o)
        else $error("strobe while deselected");
    a_read_float: assert property (!read_strobe_n_o |-> !shared_io_bus_oe_o)
        else $error("host drives bus during read");
    a_read_width: assert property ($fell(read_strobe_n_o) |-> s_read_cycle)
        else $error("read strobe cycle too short");
    a_op_known: assert property (st_r != NFH_S_IDLE |-> op_r <= NFH_OP_STATUS)
        else $error("undefined operation in progress");
    a_ready_gate: assert property (cmd_ready_o |-> rb_q_r && st_r == NFH_S_IDLE)
        else $error("ready offered while device busy");
    a_addr_full: assert property (s_cmd_strobe(`NFH_CMD_READ2) |-> acnt_h == 3'h5)
        else $error("read without five address cycles");
    a_addr_rows: assert property (s_cmd_strobe(`NFH_CMD_ERASE2) |-> acnt_h == 3'h3)
        else $error("erase without three row cycles");
    a_pair_prog: assert property (s_cmd_strobe(`NFH_CMD_PROG2) |-> op_r == NFH_OP_PROG)
        else $error("program confirm out of sequence");
    a_wait_ready: assert property (st_r == NFH_S_WAIT && !rb_q_r |=> st_r == NFH_S_WAIT)
        else $error("busy wait left while device busy");
endmodule
`default_nettype wire

// >>> core/nfh_defines.svh
// Constants of the flash host port: command codes, address cycles and timing
`ifndef NFH_DEFINES_SVH
`define NFH_DEFINES_SVH
// ----------------------------------------
// Command codes
// ----------------------------------------
`define NFH_CMD_READ1 8'h00
`define NFH_CMD_READ2 8'h30
`define NFH_CMD_PROG1 8'h80
`define NFH_CMD_PROG2 8'h10
`define NFH_CMD_ERASE1 8'h60
`define NFH_CMD_ERASE2 8'hd0
`define NFH_CMD_RESET 8'hff
`define NFH_CMD_STATUS 8'h70
// ----------------------------------------
// Address cycles
// ----------------------------------------
`define NFH_ADDR_CYC_FULL 3'h5
`define NFH_ADDR_CYC_ROW 3'h3
`define NFH_ADDR_FIRST_ROW 3'h2
// ----------------------------------------
// Timing, in ns, and derived cycle counts
// ----------------------------------------
`define NFH_CLK_NS 20
`define NFH_RD_CYCLE_NS 25
`define NFH_RD_ACCESS_NS 20
`define NFH_SETTLE_NS 100
`define NFH_RD_ACCESS_CYC ((`NFH_RD_ACCESS_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
`define NFH_SETTLE_CYC ((`NFH_SETTLE_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
// ----------------------------------------
// Page size in bytes
// ----------------------------------------
`define NFH_PAGE_BYTES 4224
`endif

// >>> core/nfh_pkg.sv
// Types of the flash host port
`default_nettype none
package nfh_pkg;
    // Operations requested on the user command port
    typedef enum logic [2:0] {
        NFH_OP_READ = 3'h0,
        NFH_OP_PROG = 3'h1,
        NFH_OP_ERASE = 3'h2,
        NFH_OP_RESET = 3'h3,
        NFH_OP_STATUS = 3'h4
    } nfh_op_t;
    // Sequencer states, one-hot
    typedef enum logic [5:0] {
        NFH_S_IDLE = 6'h01,
        NFH_S_CMD = 6'h02,
        NFH_S_ADDR = 6'h04,
        NFH_S_WDAT = 6'h08,
        NFH_S_WAIT = 6'h10,
        NFH_S_RDAT = 6'h20
    } nfh_state_t;
endpackage
`default_nettype wire

// >>> verification/nfh_ctrl_bench.sv
// Self-checking bench of the flash host port against a device model
`default_nettype none
module nfh_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import nfh_pkg::*;
    logic clk_i = 0, resetn_i = 0, cmd_valid = 0, wr_valid = 0, slow = 0;
    nfh_op_t cmd_op = NFH_OP_STATUS;
    logic [39:0] cmd_addr = '0;
    logic [12:0] cmd_len = '0;
    logic [7:0] wr_data = '0;
    logic cmd_ready, done, wr_ready, rd_valid, ce_n, cle, ale, we_n, rds_n, wp_n, bus_oe, rb_n;
    logic [7:0] rd_data, bus_o, dev_io, bus_i;
    logic [7:0] exp_q[$], wr_q[$], wb[$];
    int dev_err, n_fail = 0, checked = 0, n_done = 0;
    assign bus_i = bus_oe ? bus_o : dev_io;
    always #10 clk_i = ~clk_i;
    nfh_ctrl dut (.clk_i(clk_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op),
        .cmd_addr_i(cmd_addr), .cmd_len_i(cmd_len), .cmd_ready_o(cmd_ready), .done_o(done),
        .wr_valid_i(wr_valid), .wr_data_i(wr_data), .wr_ready_o(wr_ready), .rd_valid_o(rd_valid),
        .rd_data_o(rd_data), .ce_n_o(ce_n), .cle_o(cle), .ale_o(ale), .we_n_o(we_n),
        .read_strobe_n_o(rds_n), .wp_n_o(wp_n), .shared_io_bus_i(bus_i), .shared_io_bus_o(bus_o),
        .shared_io_bus_oe_o(bus_oe), .rb_n_i(rb_n));
    nfh_flash_model dev (.ce_n_i(ce_n), .cle_i(cle), .ale_i(ale), .we_n_i(we_n),
        .read_strobe_n_i(rds_n), .wp_n_i(wp_n), .io_i(bus_i), .io_o(dev_io), .rb_n_o(rb_n),
        .slow_i(slow), .err_o(dev_err));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Result watcher and program data feeder
    always @(posedge clk_i) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) chk("unexpected byte", 8'h00, 8'h01);
            else chk("read byte", exp_q.pop_front(), rd_data);
        end
        if (done === 1'b1) n_done++;
        if (wr_valid && wr_ready === 1'b1) void'(wr_q.pop_front());
        wr_valid <= wr_q.size() > 0;
        wr_data <= (wr_q.size() > 0) ? wr_q[0] : 8'h00;
    end
    // One request on the command port, then wait for its completion
    task automatic run_op(input nfh_op_t op, input logic [39:0] a, input logic [12:0] n);
        int d0;
        while (cmd_ready !== 1'b1) @(negedge clk_i);
        @(posedge clk_i);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_addr <= a;
        cmd_len <= n;
        @(posedge clk_i);
        cmd_valid <= 1'b0;
        d0 = n_done;
        while (n_done == d0) @(negedge clk_i);
    endtask
    function automatic logic [39:0] mk_addr(input logic [12:0] c);
        return {6'h00, 18'($urandom()), 3'h0, c};
    endfunction
    initial begin
        logic [12:0] c;
        void'($urandom(76027));
        repeat (20) @(posedge clk_i);
        chk("ce_n in reset", 8'h01, {7'h0, ce_n});
        chk("bus drive in reset", 8'h00, {7'h0, bus_oe});
        chk("wp_n in reset", 8'h00, {7'h0, wp_n});
        resetn_i <= 1'b1;
        // Status, and an undefined op taken as status
        exp_q.push_back(8'he0);
        run_op(NFH_OP_STATUS, '0, '0);
        exp_q.push_back(8'he0);
        run_op(nfh_op_t'(3'h5), '0, '0);
        run_op(NFH_OP_RESET, '0, '0);
        // Reads at a random column and at the last columns of the page
        for (int r = 0; r < 2; r++) begin
            c = r ? 13'd4218 : 13'($urandom_range(4200, 0));
            for (int i = 0; i < 6; i++) exp_q.push_back(8'(c + i) ^ 8'h3c);
            run_op(NFH_OP_READ, mk_addr(c), 13'd6);
        end
        // Program with the buffer full and the device slow, then read back
        slow = 1'b1;
        c = 13'($urandom_range(4000, 0));
        for (int i = 0; i < 10; i++) wb.push_back(8'($urandom()));
        wr_q = wb;
        repeat (14) @(negedge clk_i);
        chk("fifo refuses when full", 8'h00, {7'h0, wr_ready});
        chk("bytes left waiting", 8'h02, 8'(wr_q.size()));
        exp_q.push_back(8'he0);
        run_op(NFH_OP_PROG, mk_addr(c), 13'd10);
        slow = 1'b0;
        foreach (wb[i]) exp_q.push_back(wb[i]);
        run_op(NFH_OP_READ, mk_addr(c), 13'd10);
        // Erase, then the page reads back blank
        exp_q.push_back(8'he0);
        run_op(NFH_OP_ERASE, mk_addr(13'h0), '0);
        for (int i = 0; i < 4; i++) exp_q.push_back(8'hff);
        run_op(NFH_OP_READ, mk_addr(13'h0), 13'd4);
        repeat (4) @(negedge clk_i);
        chk("device protocol errors", 8'h00, (dev_err > 255) ? 8'hff : 8'(dev_err));
        chk("results outstanding", 8'h00, 8'(exp_q.size()));
        close_out();
    end
    // Watchdog, well beyond the expected run time
    initial begin
        #400000;
        n_fail++;
        close_out();
    end
endmodule
`default_nettype wire

// >>> verification/nfh_flash_model.sv
// Behavioural model of the flash device on the far side of the host port
`default_nettype none
module nfh_flash_model #(
    parameter int T_READ_NS = 500,
    parameter int T_PROG_NS = 2000,
    parameter int T_ERASE_NS = 3000,
    parameter int T_ACCESS_NS = 15,
    parameter logic [7:0] STAT_OK = 8'he0
) (
    // Control strobes from the host
    input wire logic ce_n_i,
    input wire logic cle_i,
    input wire logic ale_i,
    input wire logic we_n_i,
    input wire logic read_strobe_n_i,
    input wire logic wp_n_i,
    // Shared bus and ready line
    input wire logic [7:0] io_i,
    output logic [7:0] io_o,
    output logic rb_n_o,
    // Test controls and protocol error count
    input wire logic slow_i,
    output var int err_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] buf_r [0:4223]; // Page buffer
    logic [12:0] col_r; // Column counter
    logic [2:0] acnt_r; // Address cycles seen
    logic [7:0] dout_r; // Byte on the bus
    logic busy_r, stat_r, fail_r;
    realtime re_t;
    // -----------------------------
    // Pins
    // -----------------------------
    // Released bus shows the inverse of the last byte
    assign io_o = (!ce_n_i && !read_strobe_n_i) ? dout_r : ~dout_r;
    // Open drain, pulled up, blind to select
    assign rb_n_o = !busy_r;
    // Busy span runs on its own, select is ignored meanwhile
    task automatic run_busy(input int t);
        busy_r = 1'b1;
        #(slow_i ? 4 * t : t);
        busy_r = 1'b0;
    endtask
    initial begin
        for (int i = 0; i < 4224; i++) buf_r[i] = 8'(i) ^ 8'h3c;
        {busy_r, stat_r, fail_r, col_r, acnt_r, dout_r} = '0;
        err_o = 0;
        re_t = -100.0;
    end
    // Capture on write strobe rise while selected
    always @(posedge we_n_i) begin
        if (!ce_n_i) begin
            if (cle_i && ale_i) begin
                err_o++;
            end else if (cle_i) begin // Command capture
                if (busy_r && io_i != 8'h70 && io_i != 8'hff) err_o++;
                if ((io_i == 8'h30 || io_i == 8'h10 || io_i == 8'hd0) && acnt_r != 3'h5) err_o++;
                stat_r = (io_i == 8'h70);
                case (io_i)
                    8'h00, 8'h80: begin
                        acnt_r = 3'h0;
                        fail_r = 1'b0;
                    end
                    8'h60: acnt_r = 3'h2;
                    8'h30: fork run_busy(T_READ_NS); join_none
                    8'h10: if (!wp_n_i) fail_r = 1'b1; else fork run_busy(T_PROG_NS); join_none
                    8'hd0: begin // Block erase clears the buffer
                        if (!wp_n_i) fail_r = 1'b1;
                        else fork run_busy(T_ERASE_NS); join_none
                        for (int i = 0; i < 4224; i++) buf_r[i] = 8'hff;
                    end
                    8'hff: fork run_busy(100); join_none
                    8'h70: ;
                    default: err_o++; // Copy-back codes are not modelled
                endcase
            end else if (ale_i) begin // Address, column bytes first
                if (acnt_r == 3'h0) col_r[7:0] = io_i;
                if (acnt_r == 3'h1) col_r[12:8] = io_i[4:0];
                acnt_r++;
            end else if (col_r < 13'd4224) begin
                buf_r[col_r] = io_i;
                col_r++;
            end
        end
    end
    // Next byte after the access delay, column advances
    always @(negedge read_strobe_n_i) begin
        if (!ce_n_i) begin
            if ($realtime - re_t < 25.0) err_o++;
            re_t = $realtime;
            #(T_ACCESS_NS);
            dout_r = stat_r ? (STAT_OK | {7'h0, fail_r}) : buf_r[col_r];
            if (!stat_r && col_r < 13'd4223) col_r++;
        end
    end
endmodule
`default_nettype wire
